// >>> design/ifsb_flag_reg.sv
// one 16-bit flag register; unimplemented positions are constant zero
// assumes set strobes and writes come from logic on the same clock
`timescale 1ns/1ns
module ifsb_flag_reg #(
  parameter logic [15:0] IMPL_MASK = 16'h0000
) (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset, high
  input wire logic wrEn, // software write strobe
  input wire logic [15:0] wrData, // software write value
  input wire logic [15:0] setEv, // source event strobes
  output wire logic [15:0] flagQ // flag state
);

  genvar i;
  // one flop per implemented position, plain zero elsewhere
  generate
    for (i = 0; i < 16; i++) begin : gBit
      if (IMPL_MASK[i]) begin : gImpl
        logic bit_q;
        // event beats a same-cycle software clear
        always_ff @(posedge clk) begin
          if (srst) begin
            bit_q <= ifsb_pkg::FLAG_RESET[i]; // R2
          end else if (setEv[i]) begin
            bit_q <= 1'b1; // R11
          end else if (wrEn) begin
            bit_q <= wrData[i]; // R12
          end
        end
        assign flagQ[i] = bit_q; // R1
      end else begin : gNone
        assign flagQ[i] = 1'b0; // R3
      end
    end
  endgenerate

endmodule

// >>> design/ifsb_pkg.sv
// package for the interrupt flag status bank: map, field positions, carriers
// assumes a 32-bit apb slave port with byte addresses on 8 bits
package ifsb_pkg;

  // apb map, one aligned word per register
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_FLAGS_ONE = 8'h00;
  localparam logic [7:0] OFF_FLAGS_TWO = 8'h04;
  localparam logic [7:0] OFF_FLAGS_THREE = 8'h08;
  localparam logic [7:0] OFF_EN_ONE = 8'h0c;
  localparam logic [7:0] OFF_EN_TWO = 8'h10;
  localparam logic [7:0] OFF_EN_THREE = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h1c;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h20;

  // reset values
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [15:0] EN_RESET = 16'h0000;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // first flag register, low end only
  localparam int POS_CHANGE_NOTIFY = 3;
  localparam int POS_I2C_ONE_MASTER = 1;
  localparam int POS_I2C_ONE_SLAVE = 0;
  // second flag register
  localparam int POS_TIMER_SIX = 15;
  localparam int POS_DMA_CH4_DONE = 14;
  localparam int POS_COMPARE_CH8 = 12;
  localparam int POS_COMPARE_CH5 = 9;
  localparam int POS_CAPTURE_CH6 = 8;
  localparam int POS_CAPTURE_CH5 = 7;
  localparam int POS_CAPTURE_CH3 = 5;
  localparam int POS_DMA_CH3_DONE = 4;
  localparam int POS_CAN_ONE_EVENT = 3;
  localparam int POS_CAN_ONE_RX_READY = 2;
  localparam int POS_SPI_TWO_EVENT = 1;
  localparam int POS_SPI_TWO_ERROR = 0;
  // third flag register
  localparam int POS_DMA_CH5_DONE = 13;
  localparam int POS_CAN_TWO_EVENT = 8;
  localparam int POS_CAN_TWO_RX_READY = 7;
  localparam int POS_EXT_IRQ_FOUR = 6;
  localparam int POS_EXT_IRQ_THREE = 5;
  localparam int POS_TIMER_NINE = 4;
  localparam int POS_TIMER_EIGHT = 3;
  localparam int POS_I2C_TWO_MASTER = 2;
  localparam int POS_I2C_TWO_SLAVE = 1;
  localparam int POS_TIMER_SEVEN = 0;

  // implemented-bit groups built from the positions
  localparam logic [15:0] MASK_ONE = (16'h0001 << POS_CHANGE_NOTIFY)
    | (16'h0001 << POS_I2C_ONE_MASTER) | (16'h0001 << POS_I2C_ONE_SLAVE);
  localparam logic [15:0] MASK_TWO_HI = (16'h0001 << POS_TIMER_SIX)
    | (16'h0001 << POS_DMA_CH4_DONE) | (16'h001f << POS_CAPTURE_CH6);
  localparam logic [15:0] MASK_TWO_MID = (16'h0007 << POS_CAPTURE_CH3)
    | (16'h0001 << POS_DMA_CH3_DONE) | (16'h0001 << POS_CAN_ONE_EVENT)
    | (16'h0001 << POS_CAN_ONE_RX_READY);
  localparam logic [15:0] MASK_TWO_LO = (16'h0001 << POS_SPI_TWO_EVENT)
    | (16'h0001 << POS_SPI_TWO_ERROR);
  localparam logic [15:0] MASK_THREE_HI = (16'h0001 << POS_DMA_CH5_DONE)
    | (16'h0001 << POS_CAN_TWO_EVENT) | (16'h0001 << POS_CAN_TWO_RX_READY);
  localparam logic [15:0] MASK_THREE_LO = 16'h007f << POS_TIMER_SEVEN;
  localparam logic [15:0] MASK_TWO = MASK_TWO_HI | MASK_TWO_MID | MASK_TWO_LO;
  localparam logic [15:0] MASK_THREE = MASK_THREE_HI | MASK_THREE_LO;

  // one word per flag register, same layout as the registers
  typedef struct packed {
    logic [15:0] three;
    logic [15:0] two;
    logic [15:0] one;
  } ifsb_bank_s;

endpackage

// >>> design/ifsb_top.sv
// interrupt flag status bank: three flag registers, enables, apb slave
// assumes an apb3 master on clk and source strobes on the same clock
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ns

// Notes on behaviour
// [R1] A flag bit reads 1 while its source has a pending request and 0 otherwise.
// [R2] Every implemented flag is software readable and writable and resets to zero.
// [R3] Unused positions read zero: bits 15-4 and 2 of one, bit 13 of two, bits 15-14 and 12-9 of three.
// [R4] Register one holds change notify at 3, i2c one master at 1 and i2c one slave at 0.
// [R5] Register two holds timer six at 15, dma four at 14, compare 8-5 at 12-9, capture 6 at 8.
// [R6] Register two holds capture 5-3 at 7-5, dma three at 4, can one event 3, can one rx 2.
// [R7] Register two holds spi two event at bit 1 and spi two error at bit 0.
// [R8] Register three holds dma five at 13, can two event at 8, can two rx ready at 7.
// [R9] Register three holds ext irq 4-3 at 6-5, timers 9-8 at 4-3, i2c two at 2-1, timer 7 at 0.
// [R10] A set flag forwards a request only while its matching enable bit is 1.
// [R11] A flag stays set until software writes zero, and an event beats a same-cycle clear.
// [R12] Software writing 1 to an implemented flag sets it just as its source would.
module ifsb_top (
  input wire logic clk, // 100 MHz system clock
  input wire logic srst, // sync reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire ifsb_pkg::ifsb_bank_s srcEv, // source event strobes
  output ifsb_pkg::ifsb_bank_s flagsOut, // flag state
  output ifsb_pkg::ifsb_bank_s reqOut, // enabled requests
  output logic irqOut // summary interrupt, level
);

  // address match, used for every register
  function automatic logic hitOff(input logic [7:0] addr, input logic [7:0] off);
    hitOff = (addr == off);
  endfunction

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [15:0] enOne_q;
  logic [15:0] enTwo_q;
  logic [15:0] enThree_q;
  logic [2:0] irqSts_q;
  logic [2:0] irqSts_d;
  logic [2:0] irqEn_q;
  logic irqOut_q;
  ifsb_pkg::ifsb_bank_s req_q;
  wire ifsb_pkg::ifsb_bank_s flags;

  // apb phases: answer one cycle into the access phase
  wire logic accFirst = psel & penable & ~pready_q;
  wire logic accDone = psel & penable & pready_q;
  wire logic wrDone = accDone & pwrite;

  // address decode
  wire logic hitF1 = hitOff(paddr, ifsb_pkg::OFF_FLAGS_ONE);
  wire logic hitF2 = hitOff(paddr, ifsb_pkg::OFF_FLAGS_TWO);
  wire logic hitF3 = hitOff(paddr, ifsb_pkg::OFF_FLAGS_THREE);
  wire logic hitE1 = hitOff(paddr, ifsb_pkg::OFF_EN_ONE);
  wire logic hitE2 = hitOff(paddr, ifsb_pkg::OFF_EN_TWO);
  wire logic hitE3 = hitOff(paddr, ifsb_pkg::OFF_EN_THREE);
  wire logic hitSts = hitOff(paddr, ifsb_pkg::OFF_IRQ_STATUS);
  wire logic hitClr = hitOff(paddr, ifsb_pkg::OFF_IRQ_CLEAR);
  wire logic hitIen = hitOff(paddr, ifsb_pkg::OFF_IRQ_ENABLE);
  wire logic mapped = hitF1 | hitF2 | hitF3 | hitE1 | hitE2 | hitE3
    | hitSts | hitClr | hitIen;

  // read mux; the clear register is write only and reads zero
  wire logic [15:0] rdLow = hitF1 ? flags.one :
    hitF2 ? flags.two :
    hitF3 ? flags.three :
    hitE1 ? enOne_q :
    hitE2 ? enTwo_q :
    hitE3 ? enThree_q :
    hitSts ? {13'h0000, irqSts_q} :
    hitIen ? {13'h0000, irqEn_q} : 16'h0000;

  // source strobes sorted onto their documented positions
  wire logic [15:0] evOne = srcEv.one & ifsb_pkg::MASK_ONE; // R4
  wire logic [15:0] evTwoHi = srcEv.two & ifsb_pkg::MASK_TWO_HI; // R5
  wire logic [15:0] evTwoMid = srcEv.two & ifsb_pkg::MASK_TWO_MID; // R6
  wire logic [15:0] evTwoLo = srcEv.two & ifsb_pkg::MASK_TWO_LO; // R7
  wire logic [15:0] evThreeHi = srcEv.three & ifsb_pkg::MASK_THREE_HI; // R8
  wire logic [15:0] evThreeLo = srcEv.three & ifsb_pkg::MASK_THREE_LO; // R9
  wire logic [15:0] evTwo = evTwoHi | evTwoMid | evTwoLo;
  wire logic [15:0] evThree = evThreeHi | evThreeLo;
  wire logic [2:0] evAny = {|evThree, |evTwo, |evOne};
  wire logic [2:0] irqClr = (wrDone & hitClr) ? pwdata[2:0] : 3'h0;

  // enabled requests, named so the checks can look one cycle back
  wire logic [15:0] gateOne = flags.one & enOne_q; // R10
  wire logic [15:0] gateTwo = flags.two & enTwo_q; // R10
  wire logic [15:0] gateThree = flags.three & enThree_q; // R10
  wire logic [15:0] evEnTwo = evTwo & enTwo_q;

  // the three flag registers
  ifsb_flag_reg #(.IMPL_MASK(ifsb_pkg::MASK_ONE)) uFlagOne (
    .clk(clk),
    .srst(srst),
    .wrEn(wrDone & hitF1),
    .wrData(pwdata[15:0]),
    .setEv(evOne),
    .flagQ(flags.one)
  );
  ifsb_flag_reg #(.IMPL_MASK(ifsb_pkg::MASK_TWO)) uFlagTwo (
    .clk(clk),
    .srst(srst),
    .wrEn(wrDone & hitF2),
    .wrData(pwdata[15:0]),
    .setEv(evTwo),
    .flagQ(flags.two)
  );
  ifsb_flag_reg #(.IMPL_MASK(ifsb_pkg::MASK_THREE)) uFlagThree (
    .clk(clk),
    .srst(srst),
    .wrEn(wrDone & hitF3),
    .wrData(pwdata[15:0]),
    .setEv(evThree),
    .flagQ(flags.three)
  );

  // apb answer, registered so every bus output comes from a flop
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= ifsb_pkg::RDATA_RESET;
    end else begin
      pready_q <= accFirst;
      pslverr_q <= accFirst & ~mapped;
      prdata_q <= (accFirst & ~pwrite) ? {16'h0000, rdLow} : ifsb_pkg::RDATA_RESET;
    end
  end

  // enables keep only implemented positions, so unused bits read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      enOne_q <= ifsb_pkg::EN_RESET;
      enTwo_q <= ifsb_pkg::EN_RESET;
      enThree_q <= ifsb_pkg::EN_RESET;
      irqEn_q <= ifsb_pkg::IRQ_RESET;
    end else if (wrDone) begin
      if (hitE1) enOne_q <= pwdata[15:0] & ifsb_pkg::MASK_ONE;
      if (hitE2) enTwo_q <= pwdata[15:0] & ifsb_pkg::MASK_TWO;
      if (hitE3) enThree_q <= pwdata[15:0] & ifsb_pkg::MASK_THREE;
      if (hitIen) irqEn_q <= pwdata[2:0];
    end
  end

  // sticky per-register event status; a new event wins over a clear
  assign irqSts_d = (irqSts_q & ~irqClr) | evAny;
  always_ff @(posedge clk) begin
    if (srst) begin
      irqSts_q <= ifsb_pkg::IRQ_RESET;
    end else begin
      irqSts_q <= irqSts_d;
    end
  end

  // request gating; one cycle behind the flags to keep outputs on flops
  always_ff @(posedge clk) begin
    if (srst) begin
      req_q <= '0;
      irqOut_q <= 1'b0;
    end else begin
      req_q.one <= gateOne; // R10
      req_q.two <= gateTwo; // R10
      req_q.three <= gateThree; // R10
      irqOut_q <= |(irqSts_q & irqEn_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign flagsOut = flags;
  assign reqOut = req_q;
  assign irqOut = irqOut_q;

  // checks on the flag, request, status, interrupt and apb behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence rdFirst;
    psel && penable && !pready_q && !pwrite;
  endsequence
  sequence answerPulse;
    pready_q ##1 !pready_q;
  endsequence
  sequence enabledEventTwo;
    (evEnTwo != 16'h0000) && !(wrDone && hitE2);
  endsequence
  sequence statusHit;
    ((evAny & irqEn_q) != 3'h0) && !(wrDone && hitIen);
  endsequence

  flag_event_a: assert property ( // R11
    (evTwo != 16'h0000) |=> ((flags.two & $past(evTwo)) == $past(evTwo)))
    else $error("source event did not set its flag");

  flag_hold_a: assert property ( // R11
    !(wrDone && hitF3) |=> ((flags.three & $past(flags.three)) == $past(flags.three)))
    else $error("flag dropped without a software write");

  unused_zero_a: assert property ( // R3
    ((flags.one & ~ifsb_pkg::MASK_ONE) == 16'h0000)
    && ((flags.two & ~ifsb_pkg::MASK_TWO) == 16'h0000)
    && ((flags.three & ~ifsb_pkg::MASK_THREE) == 16'h0000))
    else $error("unused flag position is set");

  reset_zero_a: assert property (@(posedge clk) disable iff (1'b0) // R2
    srst |=> (flags == '0) && !irqOut && !pready)
    else $error("flags not zero after reset");

  read_back_a: assert property ( // R1
    (rdFirst and hitF2) |=> answerPulse and (prdata[15:0] == $past(flags.two)))
    else $error("flag read data wrong");

  req_gate_a: assert property ( // R10
    reqOut.two == $past(gateTwo))
    else $error("request not gated by its enable");

  sw_set_a: assert property ( // R12
    (wrDone && hitF1) |=> ((flags.one & $past(pwdata[15:0]) & ifsb_pkg::MASK_ONE)
      == ($past(pwdata[15:0]) & ifsb_pkg::MASK_ONE)))
    else $error("software write of one did not set flag");

  sw_clear_a: assert property ( // R11
    (wrDone && hitF2 && evTwo == 16'h0000)
      |=> (flags.two == ($past(pwdata[15:0]) & ifsb_pkg::MASK_TWO)))
    else $error("software write did not load flags");

  summary_irq_a: assert property (
    ((irqSts_q & irqEn_q) != 3'h0) |=> irqOut)
    else $error("summary interrupt missing");

  ev_map_one_a: assert property ( // R4
    (evOne != 16'h0000) |=> ((flags.one & $past(evOne)) == $past(evOne)))
    else $error("register one event missed its flag");

  ev_map_hi_a: assert property ( // R5
    (evTwoHi != 16'h0000) |=> ((flags.two & $past(evTwoHi)) == $past(evTwoHi)))
    else $error("register two upper event missed its flag");

  ev_map_mid_a: assert property ( // R6
    (evTwoMid != 16'h0000) |=> ((flags.two & $past(evTwoMid)) == $past(evTwoMid)))
    else $error("register two middle event missed its flag");

  ev_map_lo_a: assert property ( // R7
    (evTwoLo != 16'h0000) |=> ((flags.two & $past(evTwoLo)) == $past(evTwoLo)))
    else $error("register two spi event missed its flag");

  ev_map_dma_a: assert property ( // R8
    (evThreeHi != 16'h0000) |=> ((flags.three & $past(evThreeHi)) == $past(evThreeHi)))
    else $error("register three upper event missed its flag");

  ev_map_low_a: assert property ( // R9
    (evThreeLo != 16'h0000) |=> ((flags.three & $past(evThreeLo)) == $past(evThreeLo)))
    else $error("register three lower event missed its flag");

  change_one_a: assert property ( // R1
    !(wrDone && hitF1) |=> (flags.one == ($past(flags.one) | $past(evOne))))
    else $error("register one flag moved without cause");

  change_two_a: assert property ( // R1
    !(wrDone && hitF2) |=> (flags.two == ($past(flags.two) | $past(evTwo))))
    else $error("register two flag moved without cause");

  change_three_a: assert property ( // R1
    !(wrDone && hitF3) |=> (flags.three == ($past(flags.three) | $past(evThree))))
    else $error("register three flag moved without cause");

  req_gate_one_a: assert property ( // R10
    reqOut.one == $past(gateOne))
    else $error("register one request not gated");

  req_gate_three_a: assert property ( // R10
    reqOut.three == $past(gateThree))
    else $error("register three request not gated");

  ev_to_req_a: assert property ( // R10
    enabledEventTwo |-> ##2 ((reqOut.two & $past(evEnTwo, 2)) == $past(evEnTwo, 2)))
    else $error("enabled event did not reach its request");

  ev_to_irq_a: assert property (
    statusHit |-> ##2 irqOut)
    else $error("enabled event did not raise the interrupt");

  wait_state_a: assert property (
    accFirst |=> pready)
    else $error("bus answer not one cycle into access");

  ready_pulse_a: assert property (
    pready |=> !pready)
    else $error("bus ready held too long");

  err_unmapped_a: assert property (
    (accFirst && !mapped) |=> pslverr)
    else $error("unmapped address without error");

  err_mapped_a: assert property (
    (accFirst && mapped) |=> !pslverr)
    else $error("mapped address flagged as error");

  rd_idle_zero_a: assert property (
    !pready |-> (prdata == 32'h0000_0000))
    else $error("read data outside the answer cycle");

  status_set_a: assert property (
    (evAny != 3'h0) |=> ((irqSts_q & $past(evAny)) == $past(evAny)))
    else $error("event did not set its status bit");

  status_clear_a: assert property (
    ((irqClr & ~evAny) != 3'h0) |=> ((irqSts_q & $past(irqClr) & ~$past(evAny)) == 3'h0))
    else $error("status bit not cleared");

  sw_set_three_a: assert property ( // R12
    (wrDone && hitF3) |=> ((flags.three & $past(pwdata[15:0]) & ifsb_pkg::MASK_THREE)
      == ($past(pwdata[15:0]) & ifsb_pkg::MASK_THREE)))
    else $error("software write of one did not set register three flag");

  en_load_a: assert property ( // R10
    (wrDone && hitE2) |=> (enTwo_q == ($past(pwdata[15:0]) & ifsb_pkg::MASK_TWO)))
    else $error("enable write not loaded");

endmodule

// >>> sim/ifsb_event_src.sv
// event source model: peripheral strobes toward the flag bank
// assumes the bench commands one strobe pattern per cycle on the same clock
`timescale 1ns/1ns
module ifsb_event_src (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset, high
  input wire ifsb_pkg::ifsb_bank_s evCmd, // pattern wanted next cycle
  output ifsb_pkg::ifsb_bank_s srcEv // strobes to the bank
);
  // peripherals launch strobes from flops, so they stay quiet in reset
  always_ff @(posedge clk) begin
    if (srst) begin
      srcEv <= 48'h0;
    end else begin
      srcEv <= evCmd;
    end
  end
endmodule

// >>> sim/interrupt_flag_status_bank_bench.sv
// self-checking bench for the interrupt flag status bank
// assumes ifsb_top with its apb slave and the event source model
`timescale 1ns/1ns
module interrupt_flag_status_bank_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irqOut;
  ifsb_pkg::ifsb_bank_s evCmd = 48'h0;
  ifsb_pkg::ifsb_bank_s srcEv;
  ifsb_pkg::ifsb_bank_s flagsOut;
  ifsb_pkg::ifsb_bank_s reqOut;
  logic [31:0] rd;
  logic err;
  int errCount = 0;
  int samplesChecked = 0;
  // implemented bits per flag register
  logic [31:0] impl [3] = '{32'h0000_000b, 32'h0000_dfff, 32'h0000_21ff};

  ifsb_top DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .srcEv(srcEv), .flagsOut(flagsOut), .reqOut(reqOut), .irqOut(irqOut));
  ifsb_event_src PEER (.clk(clk), .srst(srst), .evCmd(evCmd), .srcEv(srcEv));

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic completeRun();
    if (errCount == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // strobe pattern reaches the bank one cycle later; ends where flags settled
  task automatic pulse(input ifsb_pkg::ifsb_bank_s pat);
    @(posedge clk);
    evCmd <= pat;
    @(posedge clk);
    evCmd <= 48'h0;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic reset_scan();
    for (int a = 0; a <= 32; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      check(rd, 32'h0);
    end
  endtask

  task automatic sw_round_trip();
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, 8'(4 * r), 32'hffff_ffff);
      apb(1'b0, 8'(4 * r), 32'h0);
      check(rd, impl[r]);
      apb(1'b1, 8'(4 * r), 32'h0);
      apb(1'b0, 8'(4 * r), 32'h0);
      check(rd, 32'h0);
    end
  endtask

  // every strobe position lands on its own bit, unused ones on no bit of their own register
  task automatic event_walk();
    logic [31:0] exp;
    for (int i = 0; i < 48; i++) begin
      exp = impl[i / 16] & (32'h1 << (i % 16));
      pulse(48'h1 << i);
      check({16'h0, flagsOut[16 * (i / 16) +: 16]}, exp);
      apb(1'b0, 8'(4 * (i / 16)), 32'h0);
      check(rd, exp);
      apb(1'b1, 8'(4 * (i / 16)), 32'h0);
    end
  endtask

  // a strobe present at the clearing write keeps the flag set
  task automatic event_beats_clear();
    pulse(48'h1 << 16);
    // strobe lands only on the write's accept edge: one wait state, one peer flop
    fork
      apb(1'b1, 8'h04, 32'h0);
      begin
        @(posedge clk iff (psel && !penable));
        evCmd <= 48'h1 << 16;
        @(posedge clk);
        evCmd <= 48'h0;
      end
    join
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0);
  endtask

  task automatic enable_and_irq();
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h7);
    apb(1'b1, 8'h1c, 32'h7);
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 8'h10, 32'h8000);
    apb(1'b1, 8'h20, 32'h2);
    pulse(48'h1 << 31);
    @(negedge clk);
    check({31'h0, reqOut[31]}, 32'h1);
    check({31'h0, irqOut}, 32'h1);
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, 8'h1c, 32'h2);
    apb(1'b0, 8'h1c, 32'h0);
    check({31'h0, irqOut}, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h20, 32'h0);
    pulse(48'h1 << 31);
    @(negedge clk);
    check({30'h0, flagsOut[31], reqOut[31]}, 32'h2);
    check({31'h0, irqOut}, 32'h0);
    apb(1'b1, 8'h1c, 32'h7);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check({err, rd[30:0]}, 32'h8000_0000);
  endtask

  // reset in mid-run drops flags, enables and requests
  task automatic mid_reset();
    apb(1'b1, 8'h0c, 32'hffff);
    apb(1'b1, 8'h14, 32'hffff);
    pulse((48'h1 << 32) | 48'h8);
    @(negedge clk);
    check({28'h0, flagsOut[32], reqOut[32], flagsOut[3], reqOut[3]}, 32'hf);
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check({flagsOut[47:32], reqOut[47:32]}, 32'h0);
    check({flagsOut[15:0], reqOut[15:0]}, 32'h0);
    check({31'h0, irqOut}, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0);
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    reset_scan();
    sw_round_trip();
    event_walk();
    event_beats_clear();
    enable_and_irq();
    mid_reset();
    completeRun();
  end

  // watchdog, far beyond the fewer than a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    completeRun();
  end
endmodule
